// ### inc/srx_pkg.sv
// shared constants for the receive clock-recovery control block
package srx_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] SRX_ADDR_CTRL    = 8'h00;
   localparam logic [7:0] SRX_ADDR_STATUS  = 8'h04;
   localparam logic [7:0] SRX_ADDR_INT_ST  = 8'h08;
   localparam logic [7:0] SRX_ADDR_INT_EN  = 8'h0c;
   localparam logic [7:0] SRX_ADDR_INT_CLR = 8'h10;

   // ---------------------------------------------------------------
   // control field positions and reset value
   // ---------------------------------------------------------------
   localparam int SRX_CTRL_REF_FREQ  = 0; // 0: 77.76 MHz, 1: 19.44 MHz
   localparam int SRX_CTRL_LINE_RATE = 1; // 0: 155.52 Mbps, 1: 622.08 Mbps
   localparam int SRX_CTRL_REF_SRC   = 2; // 0: synthesizer ref, 1: aux 77.76 MHz
   localparam int SRX_CTRL_BYPASS    = 3;
   localparam int SRX_CTRL_LOS_DIS   = 4;
   localparam int SRX_CTRL_RLOOP     = 5;
   localparam int SRX_CTRL_W         = 6;
   localparam logic [5:0] SRX_CTRL_RST = 6'h00;

   // ---------------------------------------------------------------
   // interrupt event bits
   // ---------------------------------------------------------------
   localparam int SRX_EV_LOS_SET   = 0;
   localparam int SRX_EV_LOS_CLR   = 1;
   localparam int SRX_EV_LOCK_LOST = 2;
   localparam int SRX_EV_DATA_LOCK = 3;
   localparam int SRX_EV_W         = 4;

   // ---------------------------------------------------------------
   // loss-of-signal and timing figures
   // ---------------------------------------------------------------
   localparam int SRX_LOS_ZEROS     = 128; // zero bits to declare
   localparam int SRX_LOS_WIN       = 128; // sliding window, bits
   localparam int SRX_LOS_CLR_TRANS = 16;  // transitions to clear
   localparam int SRX_MON_WIN_TICKS = 16384; // reference ticks per window
   localparam int SRX_PPM_SHIFT     = 11;  // 2^-11 = 488 ppm, about 500
   localparam int SRX_RX_PIPE_BYTES = 3;   // gives 31 bit periods latency
   localparam int SRX_RLOOP_DELAY   = 3;   // bit periods, serial loopback
   localparam int SRX_BITS_PER_BYTE = 8;

   // lock state machine
   typedef enum logic [1:0] {
      SRX_ST_REF_ACQ  = 2'b00,
      SRX_ST_REF_LOCK = 2'b01,
      SRX_ST_DATA     = 2'b10,
      SRX_ST_BYPASS   = 2'b11
   } srx_state_t;
endpackage : srx_pkg

// ### core/srx_los_det.sv
// internal loss-of-signal detector on the recovered bit stream
`timescale 1ns/1ps
`default_nettype none
module srx_los_det #(
   parameter int ZEROS     = srx_pkg::SRX_LOS_ZEROS,
   parameter int WIN       = srx_pkg::SRX_LOS_WIN,
   parameter int CLR_TRANS = srx_pkg::SRX_LOS_CLR_TRANS
) (
   input  wire logic i_sys_clk,
   input  wire logic i_arst_n,
   input  wire logic i_bit_stb,
   input  wire logic i_bit,
   input  wire logic i_disable,
   output logic      o_los
);
   import srx_pkg::*;

   localparam int ZW = $clog2(ZEROS + 1);
   localparam int TW = $clog2(WIN + 1);

   // ------
   // elaboration checks
   // ------
   if (ZEROS < 1 || WIN < 2 || CLR_TRANS < 1 || CLR_TRANS > WIN)
   begin : g_bad_param
      $error("srx_los_det: unsupported parameter values");
   end

   logic [WIN-1:0] hist_q, hist_d;   // one bit per received bit, set where a transition was seen
   logic [TW-1:0]  trans_q, trans_d;
   logic [ZW-1:0]  zeros_q, zeros_d;
   logic           prev_q, prev_d;
   logic           los_q, los_d;

   // ------
   // next state
   // ------
   // the transition count is kept incrementally so no wide adder tree
   always_comb
   begin
      logic edge_b;
      edge_b  = i_bit ^ prev_q;
      hist_d  = hist_q;
      trans_d = trans_q;
      zeros_d = zeros_q;
      prev_d  = prev_q;
      los_d   = los_q;
      if (i_disable)
      begin
         // monitoring stopped: flag cleared and history forgotten [RQ15]
         hist_d  = '0;
         trans_d = '0;
         zeros_d = '0;
         los_d   = 1'b0;
      end
      else if (i_bit_stb)
      begin
         prev_d  = i_bit;
         hist_d  = {hist_q[WIN-2:0], edge_b};
         trans_d = trans_q + TW'(edge_b) - TW'(hist_q[WIN-1]);
         if (i_bit)
            zeros_d = '0;
         else if (zeros_q != ZW'(ZEROS))
            zeros_d = zeros_q + 1'b1;
         if (zeros_d == ZW'(ZEROS))
            los_d = 1'b1;                             // [RQ14]
         else if (los_q && trans_d >= TW'(CLR_TRANS))
            los_d = 1'b0;                             // [RQ14]
      end
   end

   // ------
   // registers
   // ------
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         hist_q  <= '0;
         trans_q <= '0;
         zeros_q <= '0;
         prev_q  <= 1'b0;
         los_q   <= 1'b0;
      end
      else
      begin
         hist_q  <= hist_d;
         trans_q <= trans_d;
         zeros_q <= zeros_d;
         prev_q  <= prev_d;
         los_q   <= los_d;
      end
   end

   assign o_los = los_q;
endmodule : srx_los_det
`default_nettype wire

// ### core/srx_rx_ctrl.sv
// receive clock-recovery control: lock sequencing, los muting, deserialiser
//
// Overview of operation
// RQ1 - ref_freq_select 0 means a 77.76 MHz synthesizer reference and 1 means 19.44 MHz.
// RQ2 - line_rate_select 0 runs the line at 155.52 Mbps and 1 at 622.08 Mbps, whatever the reference.
// RQ3 - in normal receive a bit reaches the parallel output 25 to 35 bit periods after its MSB arrives.
// RQ4 - in serial remote loopback the MSB leaves the serial output 2 to 4 bit periods after arrival.
// RQ5 - recovered bits are packed into bytes and a byte clock of line clock divided by 8 goes out.
// RQ6 - after start, loss of signal or loss of lock the loop restarts from the reference clock.
// RQ7 - recovery_bypass turns off internal recovery and uses the externally recovered clock.
// RQ8 - the loop locks to the reference first and only then tries to follow data.
// RQ9 - a frequency error above about 500 ppm sends the loop back to the reference.
// RQ10 - during loss of lock or signal the byte clock keeps running from the reference.
// RQ11 - while external or internal loss of signal is present the parallel data read as zero.
// RQ12 - data tracking resumes only with no external or internal loss and frequency within 500 ppm.
// RQ13 - recovery_ref_source_select 1 uses the aux 77.76 MHz reference and ignores the frequency select.
// RQ14 - internal loss is declared after 128 zero bits and cleared at 16 transitions in 128 bits.
// RQ15 - internal_los_disable stops internal loss monitoring and the muting it causes.
// RQ16 - the optical module drives optical_signal_lost_n low for loss and high for normal.
// RQ17 - the lock monitor counts byte clocks against reference ticks over a window against 500 ppm.
`timescale 1ns/1ps
`default_nettype none
module srx_rx_ctrl #(
   parameter int MON_WIN_TICKS = srx_pkg::SRX_MON_WIN_TICKS,
   parameter int PIPE_BYTES    = srx_pkg::SRX_RX_PIPE_BYTES
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_arst_n,
   // register port
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [31:0] o_reg_rdata,
   output logic             o_irq,
   // serial side, one strobe per bit period
   input  wire logic        i_rec_bit_stb,
   input  wire logic        i_rx_serial_in,
   input  wire logic        i_ext_recovered_clock_stb,
   input  wire logic        i_ext_serial_in,
   input  wire logic        i_ref_clock_tick,
   input  wire logic        i_recovery_aux_ref_clock_tick,
   input  wire logic        i_optical_signal_lost_n,
   output logic             o_tx_serial_out,
   // analog loop steering
   output logic             o_loop_on_data,
   output logic             o_recovery_powerdown,
   output logic             o_ref_is_19m,
   output logic             o_line_rate_fast,
   output logic             o_recovery_ref_aux,
   // parallel side
   output logic      [7:0]  o_rx_parallel_out,
   output logic             o_rx_byte_clock
);
   import srx_pkg::*;

   localparam int MW = $clog2(MON_WIN_TICKS * 4 + 1) + 1;

   // ------
   // elaboration checks
   // ------
   // MSB latency is 7 + 8*PIPE_BYTES bit periods and must land in 25..35
   if (PIPE_BYTES != 3 || MON_WIN_TICKS < (1 << (SRX_PPM_SHIFT + 2)))
   begin : g_bad_param
      $error("srx_rx_ctrl: unsupported parameter values");
   end

   logic [SRX_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [SRX_EV_W-1:0]   int_st_q, int_st_d, int_en_q, int_en_d;
   logic [31:0]           rdata_q, rdata_d;
   logic [SRX_EV_W-1:0]   ev;
   srx_state_t            st_q, st_d;
   logic [2:0]            bitcnt_q, bitcnt_d;
   logic [7:0]            shift_q, shift_d;
   logic [7:0]            pipe_q [PIPE_BYTES], pipe_d [PIPE_BYTES];
   logic [7:0]            out_q, out_d;
   logic                  bclk_q, bclk_d;
   logic [SRX_RLOOP_DELAY-1:0] rl_q, rl_d;
   logic                  txo_q, txo_d;
   logic [MW-1:0]         tick_q, tick_d, bytes_q, bytes_d;
   logic                  freq_ok_q, freq_ok_d, win_end_q, win_end_d;
   logic                  los_int, los_int_q;
   logic                  bypass, los_dis, bit_stb, bit_in, ref_tick;
   logic                  ext_los, mute, byte_stb;
   logic [MW-1:0]         expected, tol, diff;

   // ------
   // configuration decode and source selection
   // ------
   assign bypass   = ctrl_q[SRX_CTRL_BYPASS];
   assign los_dis  = ctrl_q[SRX_CTRL_LOS_DIS];
   assign o_ref_is_19m        = ctrl_q[SRX_CTRL_REF_FREQ];   // [RQ1]
   assign o_line_rate_fast    = ctrl_q[SRX_CTRL_LINE_RATE];  // [RQ2]
   assign o_recovery_ref_aux  = ctrl_q[SRX_CTRL_REF_SRC];    // [RQ13]
   assign o_recovery_powerdown = bypass;                     // [RQ7]
   assign bit_stb  = bypass ? i_ext_recovered_clock_stb : i_rec_bit_stb;  // [RQ7]
   assign bit_in   = bypass ? i_ext_serial_in : i_rx_serial_in;           // [RQ7]
   assign ref_tick = o_recovery_ref_aux ? i_recovery_aux_ref_clock_tick
                                        : i_ref_clock_tick;               // [RQ13]
   assign ext_los  = !i_optical_signal_lost_n;               // [RQ16]
   assign mute     = ext_los || (los_int && !los_dis);       // [RQ11] [RQ15]
   assign byte_stb = bit_stb && (bitcnt_q == 3'd7);

   // expected byte clocks per window: aux ref is always 77.76 MHz
   always_comb
   begin
      logic ref_slow;
      ref_slow = o_ref_is_19m && !o_recovery_ref_aux;       // [RQ13]
      if (ref_slow == o_line_rate_fast)
         expected = ref_slow ? MW'(MON_WIN_TICKS) << 2 : MW'(MON_WIN_TICKS) >> 2;
      else
         expected = MW'(MON_WIN_TICKS);                      // [RQ1] [RQ2]
      tol  = expected >> SRX_PPM_SHIFT;
      diff = (bytes_q > expected) ? bytes_q - expected : expected - bytes_q;
   end

   srx_los_det u_los (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_bit_stb (bit_stb),
      .i_bit     (bit_in),
      .i_disable (los_dis),
      .o_los     (los_int)
   );

   // ------
   // frequency monitor and lock sequencing
   // ------
   // byte clocks keep coming in reference states, so the count also
   // confirms the loop has settled on the reference before data
   always_comb
   begin
      tick_d    = tick_q;
      bytes_d   = bytes_q + MW'(byte_stb);
      win_end_d = 1'b0;
      freq_ok_d = freq_ok_q;
      st_d      = st_q;
      if (ref_tick)
      begin
         if (tick_q == MW'(MON_WIN_TICKS - 1))
         begin
            tick_d    = '0;
            bytes_d   = MW'(byte_stb);
            win_end_d = 1'b1;
            freq_ok_d = (diff <= tol);                       // [RQ17]
         end
         else
            tick_d = tick_q + 1'b1;
      end
      case (st_q)
         SRX_ST_REF_ACQ:
            if (win_end_q && freq_ok_q)
               st_d = SRX_ST_REF_LOCK;                       // [RQ8]
         SRX_ST_REF_LOCK:
            if (win_end_q && !freq_ok_q)
               st_d = SRX_ST_REF_ACQ;
            else if (win_end_q && !mute)
               st_d = SRX_ST_DATA;                           // [RQ8] [RQ12]
         SRX_ST_DATA:
            if (mute || (win_end_q && !freq_ok_q))
               st_d = SRX_ST_REF_ACQ;                        // [RQ6] [RQ9]
         SRX_ST_BYPASS:
            st_d = SRX_ST_REF_ACQ;                           // [RQ6]
         default:
            st_d = SRX_ST_REF_ACQ;
      endcase
      if (bypass)
         st_d = SRX_ST_BYPASS;                               // [RQ7]
   end

   // the analog loop only follows data in the data state [RQ10]
   assign o_loop_on_data = (st_q == SRX_ST_DATA);

   // ------
   // deserialiser, output pipeline, byte clock and serial loopback
   // ------
   // MSB first; word done at bit 7 then three byte stages: 31 bit periods
   always_comb
   begin
      bitcnt_d = bitcnt_q;
      shift_d  = shift_q;
      pipe_d   = pipe_q;
      out_d    = out_q;
      rl_d     = rl_q;
      txo_d    = txo_q;
      if (bit_stb)
      begin
         bitcnt_d = bitcnt_q + 3'd1;                         // [RQ5]
         shift_d  = {shift_q[6:0], bit_in};
         rl_d     = {rl_q[SRX_RLOOP_DELAY-2:0], bit_in};
         txo_d    = rl_q[SRX_RLOOP_DELAY-2] && !mute;        // [RQ4]
         if (byte_stb)
         begin
            pipe_d[0] = {shift_q[6:0], bit_in};
            for (int i = 1; i < PIPE_BYTES; i++)
               pipe_d[i] = pipe_q[i-1];
            out_d = mute ? 8'h00 : pipe_q[PIPE_BYTES-1];     // [RQ3] [RQ11]
         end
      end
      if (mute)
         out_d = 8'h00;                                      // [RQ11]
      // falling byte clock edge coincides with the data update
      bclk_d = bitcnt_d[2];                                  // [RQ5] [RQ10]
   end

   assign o_tx_serial_out   = ctrl_q[SRX_CTRL_RLOOP] ? txo_q : 1'b0;  // [RQ4]
   assign o_rx_parallel_out = out_q;
   assign o_rx_byte_clock   = bclk_q;

   // ------
   // register port and interrupts
   // ------
   // events: internal los edges, fall back from data, data lock reached
   always_comb
   begin
      ev = '0;
      ev[SRX_EV_LOS_SET]   = los_int && !los_int_q;
      ev[SRX_EV_LOS_CLR]   = !los_int && los_int_q;
      ev[SRX_EV_LOCK_LOST] = (st_q == SRX_ST_DATA) && (st_d != SRX_ST_DATA);
      ev[SRX_EV_DATA_LOCK] = (st_q != SRX_ST_DATA) && (st_d == SRX_ST_DATA);
   end

   // set wins over a same-cycle clear so no event is lost
   always_comb
   begin
      ctrl_d   = ctrl_q;
      int_en_d = int_en_q;
      int_st_d = int_st_q;
      rdata_d  = '0;
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            SRX_ADDR_CTRL:    ctrl_d   = i_reg_wdata[SRX_CTRL_W-1:0];
            SRX_ADDR_INT_EN:  int_en_d = i_reg_wdata[SRX_EV_W-1:0];
            SRX_ADDR_INT_CLR: int_st_d = int_st_q & ~i_reg_wdata[SRX_EV_W-1:0];
            default:          ;
         endcase
      end
      int_st_d = int_st_d | ev;
      if (i_reg_rd)
      begin
         case (i_reg_addr)
            SRX_ADDR_CTRL:   rdata_d = {26'h0, ctrl_q};
            SRX_ADDR_STATUS: rdata_d = {26'h0, st_q, freq_ok_q, mute, ext_los,
                                        los_int};
            SRX_ADDR_INT_ST: rdata_d = {28'h0, int_st_q};
            SRX_ADDR_INT_EN: rdata_d = {28'h0, int_en_q};
            default:         rdata_d = '0;
         endcase
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_irq       = |(int_st_q & int_en_q);

   // ------
   // registers
   // ------
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ctrl_q    <= SRX_CTRL_RST;
         int_en_q  <= '0;
         int_st_q  <= '0;
         rdata_q   <= '0;
         st_q      <= SRX_ST_REF_ACQ;                        // [RQ6]
         tick_q    <= '0;
         bytes_q   <= '0;
         freq_ok_q <= 1'b0;
         win_end_q <= 1'b0;
         los_int_q <= 1'b0;
         bitcnt_q  <= '0;
         shift_q   <= '0;
         for (int i = 0; i < PIPE_BYTES; i++)
            pipe_q[i] <= '0;
         out_q     <= '0;
         bclk_q    <= 1'b0;
         rl_q      <= '0;
         txo_q     <= 1'b0;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         int_en_q  <= int_en_d;
         int_st_q  <= int_st_d;
         rdata_q   <= rdata_d;
         st_q      <= st_d;
         tick_q    <= tick_d;
         bytes_q   <= bytes_d;
         freq_ok_q <= freq_ok_d;
         win_end_q <= win_end_d;
         los_int_q <= los_int;
         bitcnt_q  <= bitcnt_d;
         shift_q   <= shift_d;
         pipe_q    <= pipe_d;
         out_q     <= out_d;
         bclk_q    <= bclk_d;
         rl_q      <= rl_d;
         txo_q     <= txo_d;
      end
   end
endmodule : srx_rx_ctrl
`default_nettype wire

// ### dv/srx_optic_model.sv
// behavioural optical module and line source feeding the receive block
`timescale 1ns/1ps
`default_nettype none
module srx_optic_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_arst_n,
   input  wire logic [7:0] i_pattern,
   input  wire logic       i_one,
   input  wire logic       i_los,
   output logic            o_bit_stb,
   output logic            o_bit,
   output logic            o_signal_lost_n
);
   logic [2:0] idx_q;
   // one line bit per system clock, pattern msb first; a lone one can be spliced in
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         idx_q           <= 3'h0;
         o_bit_stb       <= 1'b0;
         o_bit           <= 1'b0;
         o_signal_lost_n <= 1'b1;
      end
      else
      begin
         idx_q           <= idx_q + 3'h1;
         o_bit_stb       <= 1'b1;
         o_bit           <= i_one | i_pattern[3'h7 - idx_q];
         o_signal_lost_n <= !i_los;
      end
   end
endmodule : srx_optic_model
`default_nettype wire

// ### dv/srx_rx_monitor.sv
// concurrent checks on the ports of the receive control block
`timescale 1ns/1ps
`default_nettype none
module srx_rx_monitor #(
   parameter int MON_WIN_TICKS = 8192
) (
   input wire logic        i_sys_clk,
   input wire logic        i_arst_n,
   input wire logic        i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        i_rec_bit_stb,
   input wire logic        i_ref_clock_tick,
   input wire logic        i_optical_signal_lost_n,
   input wire logic        o_tx_serial_out,
   input wire logic        o_loop_on_data,
   input wire logic        o_recovery_powerdown,
   input wire logic [7:0]  o_rx_parallel_out,
   input wire logic        o_rx_byte_clock
);
   import srx_pkg::*;
   logic       bclk_q;
   logic       seen_q;
   logic       chg;
   logic [3:0] scnt_q;
   int         tcnt_q;
   // ------
   // helper counters
   // ------
   assign chg = bclk_q != o_rx_byte_clock;
   // strobes between byte clock edges; ticks since the loop last followed data
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         bclk_q <= 1'b0;
         seen_q <= 1'b0;
         scnt_q <= 4'h0;
         tcnt_q <= 0;
      end
      else
      begin
         bclk_q <= o_rx_byte_clock;
         seen_q <= seen_q | chg;
         scnt_q <= chg ? {3'h0, i_rec_bit_stb} : scnt_q + {3'h0, i_rec_bit_stb};
         tcnt_q <= o_loop_on_data ? 0 : tcnt_q + int'(i_ref_clock_tick && tcnt_q < MON_WIN_TICKS);
      end
   end
   // ------
   // assertions
   // ------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);
   sequence s_los_held;
      !i_optical_signal_lost_n ##1 !i_optical_signal_lost_n;
   endsequence
   sequence s_data_entered;
      !o_loop_on_data ##1 o_loop_on_data;
   endsequence
   AST_RD_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
      else $error("stray read data");
   AST_MUTE_PAR: assert property (s_los_held |-> o_rx_parallel_out == 8'h00)
      else $error("data not muted");
   AST_MUTE_TX: assert property (s_los_held |-> !o_tx_serial_out)
      else $error("loopback data not muted");
   AST_LEAVE_DATA: assert property (o_loop_on_data && !i_optical_signal_lost_n |-> ##[1:2] !o_loop_on_data)
      else $error("stayed on data");
   AST_BYPASS_OUT: assert property (o_recovery_powerdown && $past(o_recovery_powerdown) |-> !o_loop_on_data)
      else $error("data while bypassed");
   AST_DATA_ENTRY: assert property (s_data_entered |-> $past(i_optical_signal_lost_n))
      else $error("data entered in loss");
   AST_BYTE_CLK: assert property (chg && seen_q |-> scnt_q == 4'h4)
      else $error("byte clock half period");
   AST_REF_FIRST: assert property (s_data_entered |-> tcnt_q >= MON_WIN_TICKS)
      else $error("data before a window");
endmodule : srx_rx_monitor
bind srx_rx_ctrl srx_rx_monitor #(.MON_WIN_TICKS(MON_WIN_TICKS)) srx_rx_monitor_inst (
   .i_sys_clk, .i_arst_n, .i_reg_rd, .o_reg_rdata, .i_rec_bit_stb, .i_ref_clock_tick,
   .i_optical_signal_lost_n, .o_tx_serial_out, .o_loop_on_data, .o_recovery_powerdown,
   .o_rx_parallel_out, .o_rx_byte_clock);
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the receive clock-recovery control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import srx_pkg::*;
   logic        clk, arst_n, wr, rd, one, los, tick, stb, sbit, sig_n;
   logic        tx, on_data, pwd, r19, fast, aux, bclk, irq;
   logic [7:0]  addr, pat, rx_par;
   logic [31:0] wdata, rdata, d;
   int          err_count, num_checks, tdiv, tcnt, n, k;
   // ------
   // clock, reference ticks and instances
   // ------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // one reference tick every tdiv clocks; a wrong tdiv makes a frequency error
   always @(posedge clk)
   begin
      tcnt <= (tcnt + 1 >= tdiv) ? 0 : tcnt + 1;
      tick <= (tcnt == 0);
   end
   srx_optic_model srx_optic_model_inst (.i_sys_clk(clk), .i_arst_n(arst_n), .i_pattern(pat),
      .i_one(one), .i_los(los), .o_bit_stb(stb), .o_bit(sbit), .o_signal_lost_n(sig_n));
   srx_rx_ctrl #(.MON_WIN_TICKS(8192), .PIPE_BYTES(3)) srx_rx_ctrl_inst (.i_sys_clk(clk),
      .i_arst_n(arst_n), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
      .o_reg_rdata(rdata), .o_irq(irq), .i_rec_bit_stb(stb), .i_rx_serial_in(sbit),
      .i_ext_recovered_clock_stb(stb), .i_ext_serial_in(sbit), .i_ref_clock_tick(tick),
      .i_recovery_aux_ref_clock_tick(tick), .i_optical_signal_lost_n(sig_n),
      .o_tx_serial_out(tx), .o_loop_on_data(on_data), .o_recovery_powerdown(pwd),
      .o_ref_is_19m(r19), .o_line_rate_fast(fast), .o_recovery_ref_aux(aux),
      .o_rx_parallel_out(rx_par), .o_rx_byte_clock(bclk));
   // ------
   // shared tasks
   // ------
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask : reg_rd
   // bounded wait for the loop to reach a level; a hang ends the run
   task automatic wait_data(input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim; i++)
      begin
         @(negedge clk);
         if (on_data === lvl)
            break;
      end
      if (i == lim)
      begin
         chk(32'h0, 32'h1, "wait timed out");
         print_verdict;
      end
   endtask : wait_data
   // splice a lone one into the line and count bit periods until it shows
   task automatic measure(input logic lb, output int m);
      @(posedge clk);
      one <= 1'b1;
      @(posedge clk);
      one <= 1'b0;
      for (m = 0; m < 60; m++)
      begin
         @(negedge clk);
         if ((lb ? tx : |rx_par) === 1'b1)
            break;
      end
      m = m - 1;
   endtask : measure
   // ------
   // scenarios
   // ------
   task automatic t_regs;
      logic [7:0] a [5] = '{SRX_ADDR_CTRL, SRX_ADDR_INT_ST, SRX_ADDR_INT_EN, SRX_ADDR_INT_CLR, 8'h14};
      foreach (a[i])
      begin
         reg_rd(a[i], d);
         chk(d, 32'h0, "reset read");
      end
      reg_rd(SRX_ADDR_STATUS, d);
      chk(d & 32'hfffffff7, 32'h0, "status after reset");
   endtask : t_regs
   task automatic t_modes;
      for (int i = 0; i < 8; i++)
      begin
         reg_wr(SRX_ADDR_CTRL, 32'(i));
         chk({29'h0, aux, fast, r19}, 32'(i), "mode pins");
      end
   endtask : t_modes
   task automatic t_bypass;
      logic p;
      reg_wr(SRX_ADDR_CTRL, 32'h8);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({30'h0, d[5:4]}, {30'h0, SRX_ST_BYPASS}, "bypass state");
      chk({31'h0, pwd}, 32'h1, "recovery off");
      k = 0;
      p = bclk;
      repeat (32)
      begin
         @(negedge clk);
         k += (bclk !== p) ? 1 : 0;
         p = bclk;
      end
      chk(32'(k), 32'h8, "edges");
      reg_wr(SRX_ADDR_CTRL, 32'h0);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({30'h0, d[5:4]}, {30'h0, SRX_ST_REF_ACQ}, "restart");
   endtask : t_bypass
   task automatic t_latency;
      reg_wr(SRX_ADDR_CTRL, 32'h30);
      measure(1'b1, n);
      chk(32'(n >= 2 && n <= 4), 32'h1, "loopback delay");
      repeat (50) @(posedge clk);
      measure(1'b0, n);
      for (k = 0; k < 7 && rx_par[7 - k] !== 1'b1; k++)
         ;
      chk(32'(n + k >= 25 && n + k <= 35), 32'h1, "msb latency");
      chk(32'($countones(rx_par)), 32'h1, "one bit");
      repeat (200) @(posedge clk);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({31'h0, d[0]}, 32'h0, "monitor off");
   endtask : t_latency
   task automatic t_los_int;
      reg_wr(SRX_ADDR_INT_EN, 32'h1);
      reg_wr(SRX_ADDR_CTRL, 32'h0);
      repeat (100) @(posedge clk);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({31'h0, d[0]}, 32'h0, "early");
      repeat (40) @(posedge clk);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({31'h0, d[0]}, 32'h1, "declared");
      chk({31'h0, irq}, 32'h1, "irq raised");
      @(posedge clk) pat <= 8'h80;
      repeat (48) @(posedge clk);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({31'h0, d[0]}, 32'h1, "still lost");
      chk({24'h0, rx_par}, 32'h0, "muted");
      repeat (30) @(posedge clk);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({31'h0, d[0]}, 32'h0, "cleared");
      chk({31'h0, |rx_par}, 32'h1, "unmuted");
      reg_wr(SRX_ADDR_INT_CLR, 32'h1);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      reg_rd(SRX_ADDR_INT_ST, d);
      chk(d, 32'h2, "clear event");
   endtask : t_los_int
   task automatic t_lock;
      reg_wr(SRX_ADDR_CTRL, 32'h10);
      reg_wr(SRX_ADDR_INT_EN, 32'hc);
      repeat (26000) @(posedge clk);
      reg_rd(SRX_ADDR_STATUS, d);
      chk({30'h0, d[5:4]}, {30'h0, SRX_ST_REF_ACQ}, "no lock");
      tdiv = 2;
      wait_data(1'b1, 52000);
      reg_rd(SRX_ADDR_INT_ST, d);
      chk(d & 32'hc, 32'h8, "data lock event");
      @(posedge clk) los <= 1'b1;
      wait_data(1'b0, 6);
      repeat (3) @(negedge clk);
      chk({24'h0, rx_par}, 32'h0, "loss mute");
      d[0] = bclk;
      repeat (4) @(negedge clk);
      chk({31'h0, bclk ^ d[0]}, 32'h1, "clock in loss");
      reg_rd(SRX_ADDR_STATUS, d);
      chk(d & 32'h6, 32'h6, "loss status");
      reg_rd(SRX_ADDR_INT_ST, d);
      chk(d & 32'h4, 32'h4, "lock lost event");
      @(posedge clk) los <= 1'b0;
   endtask : t_lock
   // ------
   // main sequence
   // ------
   initial
   begin
      {arst_n, wr, rd, one, los, tick} = 6'h0;
      {addr, pat, wdata} = 48'h0;
      {err_count, num_checks, tcnt, tdiv} = {32'h0, 32'h0, 32'h0, 32'h3};
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs;
      t_modes;
      t_bypass;
      t_latency;
      t_los_int;
      t_lock;
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
